// ---- rtl/irf_defs.svh ----
`ifndef IRF_DEFS_SVH
`define IRF_DEFS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define IRF_ADDR_G0L 16'hFFE0
`define IRF_ADDR_G0H 16'hFFE1
`define IRF_ADDR_G1L 16'hFFE2
`define IRF_ADDR_G1H 16'hFFE3

// ----------------------------------------------------------------
// reset values and implemented bits
// ----------------------------------------------------------------
`define IRF_FLAG_RESET 8'h00
`define IRF_RDATA_RESET 16'h0000
`define IRF_IMPL_MASK 32'h1FFF_FFFF
`define IRF_BYTE_IMPL_ALL 8'hFF

`endif

// ---- rtl/irf_pkg.sv ----
package irf_pkg;

  // ----------------------------------------------------------------
  // state of one flag byte
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] flags;
  } irf_byte_st_t;

  // ----------------------------------------------------------------
  // state of the read port
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] rdata;
    logic rvalid;
  } irf_bank_st_t;

endpackage

// ---- rtl/irf_flag_byte.sv ----
`include "irf_defs.svh"

module irf_flag_byte
  import irf_pkg::*;
#(
  parameter logic [7:0] IMPL = `IRF_BYTE_IMPL_ALL
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // software writes
  input wire logic wr_byte_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_bit_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic bit_val_i,
  // hardware set and acknowledge clear
  input wire logic [7:0] set_i,
  input wire logic [7:0] ack_clr_i,
  // flag contents
  output logic [7:0] flags_o
);

  irf_byte_st_t st;
  irf_byte_st_t next_st;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (wr_byte_i) begin
      next_st.flags = wdata_i;
    end
    if (wr_bit_i) begin
      next_st.flags[bit_sel_i] = bit_val_i;
    end
    next_st.flags = next_st.flags & ~ack_clr_i;
    next_st.flags = next_st.flags | set_i;
    next_st.flags = next_st.flags & IMPL;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st.flags <= `IRF_FLAG_RESET;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign flags_o = st.flags;

endmodule // irf_flag_byte

// ---- rtl/irf_flag_bank.sv ----
`include "irf_defs.svh"

// Behaviour
// - a source request sets the flag; a software write of 1 sets it unless it is acknowledged in the same cycle
// - acknowledging an interrupt clears its flag unless a source request sets it in the same cycle
// - a software write of 0 clears the flag unless a source request sets it in the same cycle
// - reset clears all four flag registers to zero
// - each register accepts single-bit writes and whole-byte writes
// - low and high registers of a group read together as one word
// - four registers at consecutive byte addresses, read/write, zero at reset
// - a byte write overwrites all implemented flags (eight, five in G1H) with the written values
// - a shared flag bit is set by either of its two sources
module irf_flag_bank
  import irf_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // cpu register access
  input wire logic [15:0] addr_i,
  input wire logic wr_byte_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_bit_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic bit_val_i,
  input wire logic rd_i,
  input wire logic rd_word_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  // interrupt sources
  input wire logic [31:0] src_req_i,
  input wire logic [31:0] alt_req_i,
  // acknowledge
  input wire logic ack_i,
  input wire logic [4:0] ack_idx_i,
  // flags to priority logic
  output logic [31:0] flags_o
);

  localparam logic [31:0] IMPL_MASK = `IRF_IMPL_MASK;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_decode(input logic [15:0] a);
    logic [2:0] r;
    r = 3'h0;
    unique case (a)
      `IRF_ADDR_G0L: r = 3'h4;
      `IRF_ADDR_G0H: r = 3'h5;
      `IRF_ADDR_G1L: r = 3'h6;
      `IRF_ADDR_G1H: r = 3'h7;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] onehot32(input logic en, input logic [4:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[idx] = en;
    return v;
  endfunction

  logic [2:0] dec;
  logic hit;
  logic [1:0] idx;
  logic [31:0] set_all;
  logic [31:0] ack_vec;
  logic [31:0] bit_tgt;
  logic [3:0] byte_we;
  logic [3:0] bit_we;

  assign dec = reg_decode(addr_i);
  assign hit = dec[2];
  assign idx = dec[1:0];
  assign set_all = (src_req_i | alt_req_i) & IMPL_MASK;
  assign ack_vec = onehot32(ack_i, ack_idx_i);
  assign bit_tgt = onehot32(wr_bit_i && hit, {idx, bit_sel_i}) & IMPL_MASK;

  // ----------------------------------------------------------------
  // flag registers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_byte
    assign byte_we[g] = wr_byte_i && hit && (idx == 2'(g));
    assign bit_we[g] = wr_bit_i && hit && (idx == 2'(g));

    irf_flag_byte #(
      .IMPL(IMPL_MASK[g*8 +: 8])
    ) u_byte (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .wr_byte_i(byte_we[g]),
      .wdata_i(wdata_i),
      .wr_bit_i(bit_we[g]),
      .bit_sel_i(bit_sel_i),
      .bit_val_i(bit_val_i),
      .set_i(set_all[g*8 +: 8]),
      .ack_clr_i(ack_vec[g*8 +: 8]),
      .flags_o(flags_o[g*8 +: 8])
    );
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  irf_bank_st_t st;
  irf_bank_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.rvalid = rd_i;
    if (rd_i) begin
      next_st.rdata = `IRF_RDATA_RESET;
      if (hit && rd_word_i && !idx[0]) begin
        next_st.rdata = flags_o[idx[1]*16 +: 16];
      end else if (hit && !rd_word_i) begin
        next_st.rdata = {8'h00, flags_o[idx*8 +: 8]};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st.rdata <= `IRF_RDATA_RESET;
      st.rvalid <= 1'b0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign rvalid_o = st.rvalid;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_SRC_SETS: assert property (
    ce_i |=> ((flags_o & $past(set_all)) == $past(set_all)))
    else $error("raised request did not set its flag");

  AST_ACK_CLEARS: assert property (
    ce_i && ack_i && !set_all[ack_idx_i] |=> !flags_o[$past(ack_idx_i)])
    else $error("acknowledged flag not cleared");

  AST_BIT_CLR: assert property (
    ce_i && wr_bit_i && hit && !bit_val_i && ((bit_tgt & set_all) == 32'h0000_0000)
    |=> ((flags_o & $past(bit_tgt)) == 32'h0000_0000))
    else $error("bit clear did not clear flag");

  AST_BIT_SET: assert property (
    ce_i && wr_bit_i && hit && bit_val_i && (bit_tgt != 32'h0000_0000)
    && ((bit_tgt & ack_vec) == 32'h0000_0000)
    |=> ((flags_o & $past(bit_tgt)) == $past(bit_tgt)))
    else $error("bit set did not set flag");

  AST_BYTE_WR: assert property (
    ce_i && wr_byte_i && (addr_i == `IRF_ADDR_G0L) && !wr_bit_i
    && (ack_vec[7:0] == 8'h00)
    |=> flags_o[7:0] == ($past(wdata_i) | $past(set_all[7:0])))
    else $error("byte write did not overwrite flags");

  AST_RESERVED: assert property (
    (flags_o & ~IMPL_MASK) == 32'h0000_0000)
    else $error("unused flag bits not zero");

  AST_FREEZE: assert property (
    !ce_i |=> $stable(flags_o) && $stable(rdata_o) && $stable(rvalid_o))
    else $error("state changed with clock enable low");

  AST_WORD_READ: assert property (
    ce_i && rd_i && rd_word_i && (addr_i == `IRF_ADDR_G1L)
    |=> rvalid_o && (rdata_o == $past(flags_o[31:16])))
    else $error("word read returned wrong data");

  AST_HOLD: assert property (
    ce_i && !wr_byte_i && !wr_bit_i && !ack_i && (set_all == 32'h0000_0000)
    |=> $stable(flags_o))
    else $error("flags changed without cause");

  AST_RVALID_PULSE: assert property (
    ce_i
    |=> rvalid_o == $past(rd_i))
    else $error("read valid not one cycle after read strobe");

  AST_BYTE_READ: assert property (
    ce_i && rd_i && !rd_word_i && (addr_i == `IRF_ADDR_G0H)
    |=> rdata_o == {8'h00, $past(flags_o[15:8])})
    else $error("byte read returned wrong data");

  AST_ODD_WORD: assert property (
    ce_i && rd_i && rd_word_i && (addr_i == `IRF_ADDR_G0H)
    |=> rdata_o == 16'h0000)
    else $error("word read at odd address not zero");

  AST_LOW_WORD: assert property (
    ce_i && rd_i && rd_word_i && (addr_i == `IRF_ADDR_G0L)
    |=> rdata_o == $past(flags_o[15:0]))
    else $error("group0 word read returned wrong data");

  AST_UNMAPPED_RD: assert property (
    ce_i && rd_i && !hit
    |=> rvalid_o && (rdata_o == 16'h0000))
    else $error("unmapped read not zero");

  AST_UNMAPPED_WR: assert property (
    ce_i && (wr_byte_i || wr_bit_i) && !hit && !ack_i && (set_all == 32'h0000_0000)
    |=> $stable(flags_o))
    else $error("write to unmapped address changed flags");

  COV_SET_VS_CLR: cover property (
    ce_i && wr_bit_i && hit && !bit_val_i && ((bit_tgt & set_all) != 32'h0000_0000));
  COV_ACK: cover property (ce_i && ack_i && flags_o[ack_idx_i] ##1 !flags_o[$past(ack_idx_i)]);
  COV_WORD_READ: cover property (ce_i && rd_i && rd_word_i && hit ##1 rdata_o != 16'h0000);
  COV_BYTE_LOST: cover property (ce_i && wr_byte_i && hit ##1 flags_o == 32'h0000_0000);

endmodule // irf_flag_bank

// ---- testbench/irf_src_model.sv ----
// ----------------------------------------------------------------
// sources and core acknowledge, driven from bench commands
// ----------------------------------------------------------------
module irf_src_model
  import irf_pkg::*;
(
  // commands
  input wire logic fire_i,
  input wire logic fire_alt_i,
  input wire logic fire_ack_i,
  input wire logic [4:0] idx_i,
  // to the flag bank
  output logic [31:0] src_req_o,
  output logic [31:0] alt_req_o,
  output logic ack_o,
  output logic [4:0] ack_idx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign src_req_o = fire_i ? (32'h0000_0001 << idx_i) : 32'h0000_0000;
  assign alt_req_o = fire_alt_i ? (32'h0000_0001 << idx_i) : 32'h0000_0000;
  assign ack_o = fire_ack_i;
  assign ack_idx_o = fire_ack_i ? idx_i : ~idx_i;
endmodule // irf_src_model

// ---- testbench/tb.sv ----
`include "irf_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic wr_byte = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic wr_bit = 1'b0;
  logic [2:0] bit_sel = 3'h0;
  logic bit_val = 1'b0;
  logic rd = 1'b0;
  logic rd_word = 1'b0;
  logic [15:0] rdata;
  logic rvalid;
  logic [31:0] flags, src, alt;
  logic ack;
  logic [4:0] ack_idx;
  logic fire = 1'b0;
  logic fire_alt = 1'b0;
  logic fire_ack = 1'b0;
  logic [4:0] idx = 5'h00;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  irf_flag_bank i_irf_flag_bank (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .addr_i(addr),
    .wr_byte_i(wr_byte), .wdata_i(wdata), .wr_bit_i(wr_bit), .bit_sel_i(bit_sel),
    .bit_val_i(bit_val), .rd_i(rd), .rd_word_i(rd_word), .rdata_o(rdata), .rvalid_o(rvalid),
    .src_req_i(src), .alt_req_i(alt), .ack_i(ack), .ack_idx_i(ack_idx), .flags_o(flags));
  irf_src_model i_irf_src_model (.fire_i(fire), .fire_alt_i(fire_alt), .fire_ack_i(fire_ack),
    .idx_i(idx), .src_req_o(src), .alt_req_o(alt), .ack_o(ack), .ack_idx_o(ack_idx));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic results;
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_errors++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_byte = 1'b1;
    @(negedge clk);
    wr_byte = 1'b0;
    @(negedge clk);
  endtask

  task automatic wbit(input logic [15:0] a, input logic [2:0] b, input logic v);
    addr = a;
    bit_sel = b;
    bit_val = v;
    wr_bit = 1'b1;
    @(negedge clk);
    wr_bit = 1'b0;
    @(negedge clk);
  endtask

  task automatic rdc(input logic [15:0] a, input logic w, input logic [15:0] exp);
    addr = a;
    rd_word = w;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk({15'h0000, rvalid, rdata}, {15'h0000, 1'b1, exp});
    @(negedge clk);
  endtask

  task automatic hw(input logic [4:0] i, input logic [2:0] kind);
    idx = i;
    {fire_ack, fire_alt, fire} = kind;
    @(negedge clk);
    {fire_ack, fire_alt, fire} = 3'h0;
    @(negedge clk);
  endtask

  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(flags, 32'h0000_0000);
    rdc(`IRF_ADDR_G1H, 1'b0, 16'h0000);
    wb(`IRF_ADDR_G0L, 8'hA5);
    wb(`IRF_ADDR_G0H, 8'h3C);
    wb(`IRF_ADDR_G1L, 8'h5A);
    wb(`IRF_ADDR_G1H, 8'h1F);
    chk(flags, 32'h1F5A_3CA5);
    rdc(`IRF_ADDR_G0L, 1'b1, 16'h3CA5);
    rdc(`IRF_ADDR_G1L, 1'b1, 16'h1F5A);
    rdc(`IRF_ADDR_G1H, 1'b0, 16'h001F);
    wbit(`IRF_ADDR_G0H, 3'h2, 1'b0);
    chk(flags, 32'h1F5A_38A5);
    rdc(`IRF_ADDR_G0H, 1'b0, 16'h0038);
    rdc(`IRF_ADDR_G0H, 1'b1, 16'h0000);
    wbit(`IRF_ADDR_G0L, 3'h1, 1'b1);
    chk(flags, 32'h1F5A_38A7);
    hw(5'd5, 3'h4);
    chk(flags, 32'h1F5A_3887);
    hw(5'd16, 3'h1);
    hw(5'd21, 3'h2);
    chk(flags, 32'h1F7B_3887);
    idx = 5'd16;
    fire = 1'b1;
    wbit(`IRF_ADDR_G1L, 3'h0, 1'b0);
    chk(flags, 32'h1F7B_3887);
    idx = 5'd3;
    wb(`IRF_ADDR_G0L, 8'h00);
    fire = 1'b0;
    chk(flags, 32'h1F7B_3808);
    ce = 1'b0;
    wb(`IRF_ADDR_G0L, 8'hFF);
    ce = 1'b1;
    wb(16'hFFE4, 8'hFF);
    chk(flags, 32'h1F7B_3808);
    rdc(16'hFFE4, 1'b0, 16'h0000);
    // standby, then a spurious request on a converter flag
    ce = 1'b0;
    repeat (4) @(negedge clk);
    ce = 1'b1;
    hw(5'h12, 3'h1);
    chk(flags, 32'h1F7F_3808);
    wbit(`IRF_ADDR_G1L, 3'h2, 1'b0);
    chk(flags, 32'h1F7B_3808);
    rst_n = 1'b0;
    @(negedge clk);
    chk(flags, 32'h0000_0000);
    rst_n = 1'b1;
    @(negedge clk);
    results();
  end
endmodule // tb
